//--- pkg/cmsr_pkg.sv
// Package of constants and types for the configuration start and reload logic
package cmsr_pkg;

   // ------------------------------------------------------------
   // Mode selector encodings
   // ------------------------------------------------------------
   localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
   localparam logic [2:0] MODE_SERIAL_FLASH  = 3'h1;
   localparam logic [2:0] MODE_PFLASH_UP     = 3'h2;
   localparam logic [2:0] MODE_PFLASH_DOWN   = 3'h3;
   localparam logic [2:0] MODE_SCAN_ONLY     = 3'h5;
   localparam logic [2:0] MODE_SLAVE_PAR     = 3'h6;
   localparam logic [2:0] MODE_SLAVE_SER     = 3'h7;

   // ------------------------------------------------------------
   // Flash addressing
   // ------------------------------------------------------------
   localparam int         ADDR_W       = 20;
   localparam logic [19:0] ADDR_BOTTOM = 20'h00000;
   localparam logic [19:0] ADDR_TOP    = 20'hfffff;

   // ------------------------------------------------------------
   // Borrowed pin counts
   // ------------------------------------------------------------
   localparam logic [5:0] PINS_MASTER_SERIAL = 6'h08;
   localparam logic [5:0] PINS_SERIAL_FLASH  = 6'h0d;
   localparam logic [5:0] PINS_PFLASH        = 6'h2e;
   localparam logic [5:0] PINS_SLAVE_PAR     = 6'h15;
   localparam logic [5:0] PINS_SLAVE_SER     = 6'h08;
   localparam logic [5:0] PINS_SCAN          = 6'h00;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 40;
   localparam int RELOAD_PULSE_NS  = 300;
   localparam int RELOAD_PULSE_CYC =
      (RELOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [2:0] MODE_RESET = 3'h0;

   // ------------------------------------------------------------
   // Clock source and decoded mode
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CSRC_OSC  = 2'h0,
      CSRC_PIN  = 2'h1,
      CSRC_TEST = 2'h2
   } cmsr_clk_src_t;

   typedef struct packed {
      logic          pflash;
      logic          slave_par;
      logic          scan_only;
      logic          byte_wide;
      logic          count_down;
      cmsr_clk_src_t clk_src;
      logic [5:0]    pins;
   } cmsr_mode_info_t;

   typedef struct packed {
      logic       chip_enable_n;
      logic       output_enable_n;
      logic       count_down;
      logic [19:0] start_addr;
   } cmsr_flash_ctl_t;

endpackage

//--- verilog/cmsr_sync.sv
// Two flip-flop synchroniser for a bus of external levels
`timescale 1ns/1ns
module cmsr_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_ff  <= rst_val;
         sync_out <= rst_val;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule

//--- verilog/cmsr_config_start.sv
// Configuration mode capture, parallel flash control and image reload
`timescale 1ns/1ns
//
// Behaviour
// - Mode selector captured when the init status output rises.
// - Selector decodes to serial, flash, parallel, slave and scan modes.
// - Master modes use oscillator, slave modes config clock, scan test clock.
// - Parallel flash and slave parallel are byte wide, others bit wide.
// - Direction bit 0 counts up from 0, 1 counts down from top.
// - Selector held valid while sampled; pins released after done.
// - Pull-up control 0 enables, 1 disables pull-ups during load.
// - Flash chip and output enables driven low during parallel flash load.
// - Config clock and busy driven during load; select-out held high.
// - After load all config pins go to user except done, request.
// - Keep-port option holds parallel port and upper address after load.
// - Reload off by default, only in parallel flash, single device.
// - Low pulse of 300 ns on trigger reloads from opposite flash end.
// - Reload drives flash pins as at first load, no program request.
// - Program request low overrides reload, restarts at mode end.
// - Borrowed pin counts: 8, 13, 46, 21, 8 and 0.
// - Scan mode waits for test port load; other modes disabled.
//
module cmsr_config_start #(
   parameter int PULSE_CYC = cmsr_pkg::RELOAD_PULSE_CYC
) (
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   input  wire logic [2:0]                mode_select_pins,
   input  wire logic                      boot_direction_select,
   input  wire logic                      pullup_disable,
   input  wire logic                      program_request_n,
   input  wire logic                      init_done,
   input  wire logic                      config_done,
   input  wire logic                      image_reload_trigger,
   input  wire logic                      reload_enable,
   input  wire logic                      single_device,
   input  wire logic                      keep_config_port,
   input  wire logic                      configuration_clock,
   output logic                           init_status,
   output logic                           config_active,
   output logic                           user_pins_released,
   output logic                           keep_port_active,
   output logic                           pullups_enabled,
   output logic                           flash_chip_enable,
   output logic                           flash_output_enable,
   output logic                           high_drive_control,
   output logic                           chip_select_out_n,
   output logic                           cfg_clk_out,
   output logic                           cfg_clk_out_en_n,
   output logic                           busy_out_en_n,
   output logic                           reload_request,
   output logic [2:0]                     captured_mode,
   output cmsr_pkg::cmsr_mode_info_t      mode_info,
   output cmsr_pkg::cmsr_flash_ctl_t      flash_ctl,
   output logic                           cfg_clk_edge
);
   import cmsr_pkg::*;

   // ------------------------------------------------------------
   // Decode function
   // ------------------------------------------------------------
   function automatic cmsr_mode_info_t decode_mode(input logic [2:0] m);
      cmsr_mode_info_t d;
      d = '0;
      d.clk_src = CSRC_OSC;
      case (m)
         MODE_MASTER_SERIAL: d.pins = PINS_MASTER_SERIAL;
         MODE_SERIAL_FLASH:  d.pins = PINS_SERIAL_FLASH;
         MODE_PFLASH_UP, MODE_PFLASH_DOWN: begin
            d.pflash    = 1'b1;
            d.byte_wide = 1'b1;
            d.count_down = (m == MODE_PFLASH_DOWN);
            d.pins      = PINS_PFLASH;
         end
         MODE_SLAVE_PAR: begin
            d.slave_par = 1'b1;
            d.byte_wide = 1'b1;
            d.clk_src   = CSRC_PIN;
            d.pins      = PINS_SLAVE_PAR;
         end
         MODE_SLAVE_SER: begin
            d.clk_src = CSRC_PIN;
            d.pins    = PINS_SLAVE_SER;
         end
         MODE_SCAN_ONLY: begin
            d.scan_only = 1'b1;
            d.clk_src   = CSRC_TEST;
            d.pins      = PINS_SCAN;
         end
         default: d.pins = PINS_SCAN;
      endcase
      return d;
   endfunction

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [7:0] raw_in;
   logic [7:0] syn_in;
   assign raw_in = {mode_select_pins, boot_direction_select,
                    program_request_n, image_reload_trigger,
                    configuration_clock, pullup_disable};

   cmsr_sync #(.W(8)) u_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (raw_in),
      .rst_val  (8'h04),
      .sync_out (syn_in)
   );

   logic [2:0] mode_s;
   logic       dir_s;
   logic       prog_n_s;
   logic       trig_s;
   logic       configuration_clock_s;
   logic       pud_s;
   assign mode_s   = syn_in[7:5];
   assign dir_s    = syn_in[4];
   assign prog_n_s = syn_in[3];
   assign trig_s   = syn_in[2];
   assign configuration_clock_s   = syn_in[1];
   assign pud_s    = syn_in[0];

   cmsr_mode_info_t dec_s;
   assign dec_s = decode_mode(mode_s);

   // ------------------------------------------------------------
   // Load sequence state machine
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_CLEAR = 2'b00,
      ST_LOAD  = 2'b01,
      ST_USER  = 2'b11,
      ST_SCAN  = 2'b10
   } cmsr_state_t;

   cmsr_state_t state_ff;
   cmsr_state_t nxt_state;
   logic        reload_go;
   logic        reload_pend_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_CLEAR: begin
            if (init_done && prog_n_s) begin
               if (dec_s.scan_only) begin
                  nxt_state = ST_SCAN;
               end else begin
                  nxt_state = ST_LOAD;
               end
            end
         end
         ST_LOAD: begin
            if (config_done) begin
               nxt_state = ST_USER;
            end
         end
         ST_USER: begin
            if (reload_go) begin
               nxt_state = ST_LOAD;
            end
         end
         ST_SCAN: begin
            if (config_done) begin
               nxt_state = ST_USER;
            end
         end
         default: nxt_state = ST_CLEAR;
      endcase
      if (!prog_n_s) begin
         nxt_state = ST_CLEAR;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_ff <= ST_CLEAR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // Mode capture and held value
   // ------------------------------------------------------------
   logic start_load;
   assign start_load = (state_ff == ST_CLEAR) && (nxt_state != ST_CLEAR);

   logic [2:0]      mode_ff;
   logic            dir_ff;
   cmsr_mode_info_t dec_ff;
   assign dec_ff = decode_mode(mode_ff);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode_ff <= MODE_RESET;
         dir_ff  <= 1'b0;
      end else if (start_load) begin
         mode_ff <= mode_s;
         dir_ff  <= dir_s;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         init_status <= 1'b0;
      end else begin
         init_status <= (nxt_state != ST_CLEAR);
      end
   end

   // ------------------------------------------------------------
   // Alternate image reload
   // ------------------------------------------------------------
   logic [7:0] low_cnt_ff;
   logic       trig_d_ff;
   logic       reload_allowed;

   assign reload_allowed = reload_enable && single_device
                           && dec_ff.pflash;
   assign reload_go = reload_pend_ff;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         trig_d_ff  <= 1'b1;
         low_cnt_ff <= 8'h00;
      end else begin
         trig_d_ff <= trig_s;
         if (trig_s) begin
            low_cnt_ff <= 8'h00;
         end else if (low_cnt_ff != 8'hff) begin
            low_cnt_ff <= low_cnt_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reload_pend_ff <= 1'b0;
      end else begin
         reload_pend_ff <= trig_s && !trig_d_ff && prog_n_s
                           && (low_cnt_ff >= 8'(PULSE_CYC))
                           && reload_allowed
                           && (state_ff == ST_USER);
      end
   end

   // Each reload flips the flash end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flash_ctl.count_down <= 1'b0;
      end else if (start_load) begin
         flash_ctl.count_down <= dir_s;
      end else if (reload_go) begin
         flash_ctl.count_down <= !flash_ctl.count_down;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flash_ctl.start_addr <= ADDR_BOTTOM;
      end else if (start_load) begin
         flash_ctl.start_addr <= dir_s ? ADDR_TOP : ADDR_BOTTOM;
      end else if (reload_go) begin
         flash_ctl.start_addr <= flash_ctl.count_down ? ADDR_BOTTOM
                                                      : ADDR_TOP;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reload_request <= 1'b0;
      end else begin
         reload_request <= reload_go;
      end
   end

   // ------------------------------------------------------------
   // Pin control outputs
   // ------------------------------------------------------------
   logic loading;
   logic pflash_load;
   assign loading = (nxt_state == ST_LOAD);
   assign pflash_load = loading
                        && (start_load ? dec_s.pflash : dec_ff.pflash);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flash_chip_enable   <= 1'b1;
         flash_output_enable <= 1'b1;
         high_drive_control  <= 1'b1;
         flash_ctl.chip_enable_n   <= 1'b1;
         flash_ctl.output_enable_n <= 1'b1;
      end else begin
         flash_chip_enable   <= !pflash_load;
         flash_output_enable <= !pflash_load;
         high_drive_control  <= !loading;
         flash_ctl.chip_enable_n   <= !pflash_load;
         flash_ctl.output_enable_n <= !pflash_load;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         config_active      <= 1'b0;
         chip_select_out_n  <= 1'b1;
         cfg_clk_out_en_n   <= 1'b1;
         busy_out_en_n      <= 1'b1;
         user_pins_released <= 1'b0;
         keep_port_active   <= 1'b0;
         pullups_enabled    <= 1'b0;
      end else begin
         config_active      <= loading;
         chip_select_out_n  <= 1'b1;
         cfg_clk_out_en_n   <= !loading;
         busy_out_en_n      <= !loading;
         user_pins_released <= (nxt_state == ST_USER);
         keep_port_active   <= (nxt_state == ST_USER)
                               && keep_config_port;
         pullups_enabled    <= (nxt_state != ST_USER) && !pud_s;
      end
   end

   // ------------------------------------------------------------
   // Clock source and decoded outputs
   // ------------------------------------------------------------
   logic       configuration_clock_d_ff;
   logic [1:0] div_ff;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         configuration_clock_d_ff    <= 1'b0;
         cfg_clk_edge <= 1'b0;
         div_ff       <= 2'h0;
         cfg_clk_out  <= 1'b0;
      end else begin
         configuration_clock_d_ff    <= configuration_clock_s;
         div_ff       <= div_ff + 2'h1;
         cfg_clk_edge <= (mode_info.clk_src == CSRC_PIN)
                         ? (configuration_clock_s && !configuration_clock_d_ff)
                         : (div_ff == 2'h3);
         cfg_clk_out  <= loading && (mode_info.clk_src == CSRC_OSC)
                         && div_ff[1];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         captured_mode <= MODE_RESET;
         mode_info     <= '0;
      end else begin
         captured_mode <= mode_ff;
         mode_info     <= decode_mode(mode_ff);
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   mode_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !start_load |=> $stable(mode_ff))
      else $error("captured mode changed outside start");

   mode_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      start_load |=> mode_ff == $past(mode_s))
      else $error("mode not captured at start");

   flash_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_ff == ST_LOAD && nxt_state == ST_LOAD && dec_ff.pflash
      |=> !flash_chip_enable && !flash_output_enable
          && !flash_ctl.chip_enable_n)
      else $error("flash enables not low during load");

   start_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      start_load && dir_s |=> flash_ctl.start_addr == ADDR_TOP)
      else $error("down start address wrong");

   reload_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reload_go |-> $past(reload_allowed))
      else $error("reload when not allowed");

   reload_flip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reload_go && prog_n_s |=>
      flash_ctl.count_down != $past(flash_ctl.count_down))
      else $error("reload did not flip flash end");

   prog_over_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !prog_n_s |=> state_ff == ST_CLEAR ##1 !user_pins_released)
      else $error("program request did not override");

   drive_cfg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_ff == ST_LOAD && nxt_state == ST_LOAD
      |=> !busy_out_en_n && !cfg_clk_out_en_n)
      else $error("config outputs not driven");

   scan_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_ff == ST_SCAN |-> !loading)
      else $error("scan mode started other load");

endmodule

//--- dv/cmsr_host_model.sv
// Model of the external host and flash side of the configuration pins
`timescale 1ns/1ns
module cmsr_host_model #(
   parameter int HALF_NS = 160
) (
   input  wire logic clk_run,
   input  wire logic hold_off,
   output logic      configuration_clock,
   output logic      program_request_n,
   output logic      chip_select_n,
   output logic      write_enable_n
);
   // ------------------------------------------------------------
   // Static pin levels
   // ------------------------------------------------------------
   assign chip_select_n     = 1'h0;
   assign write_enable_n    = 1'h0;
   // Holding the request low keeps the device off the shared flash
   assign program_request_n = ~hold_off;

   // ------------------------------------------------------------
   // Link clock
   // ------------------------------------------------------------
   // Runs only while clk_run is high and stands low otherwise
   initial begin
      configuration_clock = 1'h0;
      #7;
      forever begin
         #HALF_NS;
         configuration_clock = clk_run ? ~configuration_clock : 1'h0;
      end
   end
endmodule

//--- dv/tb.sv
// Self-checking bench for the configuration start and reload logic
`timescale 1ns/1ns
module tb;
   import cmsr_pkg::*;
   localparam int PC = RELOAD_PULSE_CYC;
   typedef struct packed {
      logic [2:0]      mode;
      cmsr_mode_info_t info;
   } cmsr_row_t;
   logic            sys_clk = 1'h0;
   logic            rst_n, boot_direction_select, pullup_disable;
   logic            init_done, config_done, image_reload_trigger;
   logic            reload_enable, single_device, keep_config_port;
   logic            clk_run, hold_off, program_request_n;
   logic            configuration_clock, init_status, config_active;
   logic            user_pins_released, keep_port_active;
   logic            pullups_enabled, flash_chip_enable;
   logic            flash_output_enable, high_drive_control;
   logic            chip_select_out_n, cfg_clk_out, cfg_clk_out_en_n;
   logic            busy_out_en_n, reload_request, cfg_clk_edge, got;
   logic [2:0]      mode_select_pins, captured_mode;
   cmsr_mode_info_t mode_info;
   cmsr_flash_ctl_t flash_ctl;
   cmsr_row_t       rows [7];
   int              n_errors = 0;
   int              n_checks = 0;
   int              cyc = 0;
   int              n, cnt;

   cmsr_config_start #(.PULSE_CYC(PC)) u_cmsr_config_start (
      .sys_clk, .rst_n, .mode_select_pins, .boot_direction_select,
      .pullup_disable, .program_request_n, .init_done, .config_done,
      .image_reload_trigger, .reload_enable, .single_device,
      .keep_config_port, .configuration_clock, .init_status,
      .config_active, .user_pins_released, .keep_port_active,
      .pullups_enabled, .flash_chip_enable, .flash_output_enable,
      .high_drive_control, .chip_select_out_n, .cfg_clk_out,
      .cfg_clk_out_en_n, .busy_out_en_n, .reload_request,
      .captured_mode, .mode_info, .flash_ctl, .cfg_clk_edge
   );
   cmsr_host_model u_cmsr_host_model (
      .clk_run, .hold_off, .configuration_clock, .program_request_n,
      .chip_select_n(), .write_enable_n()
   );

   always #20 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         end_of_test;
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test;
      if (n_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check_reset;
      check("init_status", init_status, 1'h0);
      check("flash_ce", flash_chip_enable, 1'h1);
      check("flash_oe", flash_output_enable, 1'h1);
      check("captured", captured_mode, MODE_RESET);
      check("released", user_pins_released, 1'h0);
      check("reload_req", reload_request, 1'h0);
   endtask

   task automatic cfg_start(input logic [2:0] m, input logic d);
      int k;
      hold_off = 1'h1;
      init_done = 1'h0;
      config_done = 1'h0;
      mode_select_pins = m;
      boot_direction_select = d;
      repeat (5) @(negedge sys_clk);
      hold_off = 1'h0;
      init_done = 1'h1;
      for (k = 0; k < 30 && init_status !== 1'h1; k++)
         @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
   endtask

   task automatic finish_cfg;
      int k;
      config_done = 1'h1;
      for (k = 0; k < 20 && user_pins_released !== 1'h1; k++)
         @(negedge sys_clk);
      @(negedge sys_clk);
      check("released", user_pins_released, 1'h1);
      check("active", config_active, 1'h0);
      check("clk_en_n", cfg_clk_out_en_n, 1'h1);
      check("busy_en_n", busy_out_en_n, 1'h1);
   endtask

   // Done flag falls when the trigger returns high, as a reload starts
   task automatic pulse(input int len, output logic seen);
      int k;
      seen = 1'h0;
      image_reload_trigger = 1'h0;
      for (k = 0; k < len + 14; k++) begin
         if (k == len) begin
            image_reload_trigger = 1'h1;
            config_done = 1'h0;
         end
         @(negedge sys_clk);
         if (reload_request === 1'h1)
            seen = 1'h1;
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rows[0] = {MODE_MASTER_SERIAL, 5'h00, CSRC_OSC, PINS_MASTER_SERIAL};
      rows[1] = {MODE_SERIAL_FLASH, 5'h00, CSRC_OSC, PINS_SERIAL_FLASH};
      rows[2] = {MODE_PFLASH_UP, 5'h12, CSRC_OSC, PINS_PFLASH};
      rows[3] = {MODE_PFLASH_DOWN, 5'h13, CSRC_OSC, PINS_PFLASH};
      rows[4] = {MODE_SLAVE_PAR, 5'h0a, CSRC_PIN, PINS_SLAVE_PAR};
      rows[5] = {MODE_SLAVE_SER, 5'h00, CSRC_PIN, PINS_SLAVE_SER};
      rows[6] = {MODE_SCAN_ONLY, 5'h04, CSRC_TEST, PINS_SCAN};
      rst_n = 1'h0;
      hold_off = 1'h1;
      clk_run = 1'h0;
      mode_select_pins = 3'h0;
      boot_direction_select = 1'h0;
      pullup_disable = 1'h0;
      init_done = 1'h0;
      config_done = 1'h0;
      image_reload_trigger = 1'h1;
      reload_enable = 1'h0;
      single_device = 1'h1;
      keep_config_port = 1'h0;
      repeat (10) @(negedge sys_clk);
      check_reset;
      rst_n = 1'h1;
      repeat (3) @(negedge sys_clk);
      for (n = 0; n < 7; n++) begin
         pullup_disable = n[0];
         keep_config_port = rows[n].info.slave_par;
         clk_run = (rows[n].info.clk_src == CSRC_PIN);
         cfg_start(rows[n].mode, rows[n].info.count_down);
         check("mode", captured_mode, rows[n].mode);
         check("info", mode_info, rows[n].info);
         check("ce", flash_chip_enable, !rows[n].info.pflash);
         check("oe", flash_output_enable, !rows[n].info.pflash);
         check("fc_ce", flash_ctl.chip_enable_n,
               !rows[n].info.pflash);
         check("fc_oe", flash_ctl.output_enable_n,
               !rows[n].info.pflash);
         check("pullups", pullups_enabled, !pullup_disable);
         check("cs_out_n", chip_select_out_n, 1'h1);
         if (rows[n].info.pflash)
            check("start", flash_ctl.start_addr, rows[n].info.count_down ?
                  ADDR_TOP : ADDR_BOTTOM);
         if (!rows[n].info.scan_only) begin
            check("active", config_active, 1'h1);
            check("clk_en_n", cfg_clk_out_en_n, 1'h0);
            check("busy_en_n", busy_out_en_n, 1'h0);
            check("hdc", high_drive_control, 1'h0);
         end
         cnt = 0;
         repeat (64) begin
            @(negedge sys_clk);
            if ((clk_run ? cfg_clk_edge : cfg_clk_out) === 1'h1)
               cnt++;
         end
         if (clk_run)
            check("edges", cnt inside {[7:17]}, 1'h1);
         else
            check("osc_clk", cnt inside {[16:48]},
                  !rows[n].info.scan_only);
         mode_select_pins = ~rows[n].mode;
         repeat (6) @(negedge sys_clk);
         check("held", captured_mode, rows[n].mode);
         clk_run = 1'h0;
         finish_cfg;
         check("keep", keep_port_active, keep_config_port);
      end
      // Reload refused: disabled, several devices, serial mode
      keep_config_port = 1'h0;
      for (n = 0; n < 3; n++) begin
         reload_enable = (n != 0);
         single_device = (n != 1);
         cfg_start(n == 2 ? MODE_SLAVE_SER : MODE_PFLASH_UP, 1'h0);
         finish_cfg;
         pulse(PC + 3, got);
         check("refused", got, 1'h0);
      end
      cfg_start(MODE_PFLASH_UP, 1'h0);
      finish_cfg;
      pulse(PC - 1, got);
      check("short", got, 1'h0);
      pulse(PC + 3, got);
      check("reload", got, 1'h1);
      check("rl_dn", flash_ctl.count_down, 1'h1);
      check("rl_top", flash_ctl.start_addr, ADDR_TOP);
      check("rl_ce", flash_chip_enable, 1'h0);
      check("rl_oe", flash_output_enable, 1'h0);
      check("rl_act", config_active, 1'h1);
      hold_off = 1'h1;
      repeat (6) @(negedge sys_clk);
      check("prog_clr", init_status, 1'h0);
      cfg_start(MODE_PFLASH_UP, 1'h0);
      check("prog_dn", flash_ctl.count_down, 1'h0);
      check("prog_bot", flash_ctl.start_addr, ADDR_BOTTOM);
      rst_n = 1'h0;
      repeat (3) @(negedge sys_clk);
      check_reset;
      rst_n = 1'h1;
      repeat (3) @(negedge sys_clk);
      end_of_test;
   end
endmodule
